// [logic/swgl_link.sv]
/*
 * Device end of the single-wire gauge link: reset/presence, write and read
 * slots LSB first, erase timer, hourly calibration strobe and count split.
 * Assumes the data pin has an external pull-up; oe high pulls it low.
 */
`timescale 1ns/100ps
module swgl_link
	import swgl_pkg::*;
#(
	// One hour of cycles overflows 32 bits, so 64-bit; shorten in sim
	parameter longint CAL_PERIOD_CYC = longint'(T_CAL_S) * 1_000_000 * C_US
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic single_wire_data_pin_i, // Pin level, asynchronous
	output logic single_wire_data_pin_o, // Always low when driven
	output logic single_wire_data_pin_oe, // High pulls line low
	output logic rx_valid, // One-cycle pulse, byte received
	output logic [7:0] rx_byte, // Received byte, LSB first
	input wire logic [7:0] tx_byte, // Byte for next read slots
	output logic tx_taken, // Pulse when tx_byte latched
	input wire logic sleep_req, // Enter low-power mode
	output logic awake, // Device awake
	input wire logic erase_start, // Start block erase
	input wire logic [7:0] erase_bytes, // Bytes to erase
	output logic erase_busy, // Erase in progress
	output logic cal_strobe, // Hourly offset calibration pulse
	input wire logic vfc_pulse, // Converter count pulse
	input wire logic vfc_sign_chg, // High for charge direction
	input wire logic [15:0] cal_offset, // Offset compensation counts
	output logic [15:0] chg_count, // Charge counts
	output logic [15:0] dis_count // Discharge counts
);
	typedef enum {SWGL_IDLE, SWGL_LOW, SWGL_WAITHI, SWGL_PDH, SWGL_PDL,
		SWGL_RDLOW} swgl_state_e;
	swgl_state_e state_r; // Slot state
	logic sync1_r, sync2_r, line_d_r; // Pin synchroniser and history
	logic [CNT_W-1:0] cnt_r; // Time since slot event
	logic [2:0] bit_r; // Bit index in byte
	logic [7:0] sh_r, tx_r; // Shift registers
	logic tx_ok_r; // tx_r holds data
	logic [17:0] er_cnt_r; // Erase countdown
	logic [36:0] cal_cnt_r; // Period counter, 37 bits span an hour
	logic [CNT_W-1:0] wake_r; // Wake-up delay
	logic fall; // Line seen going low
	logic rise; // Line seen going high
	logic dis_inc; // Discharge count due this cycle
	// Edges come from synchronised copies only, so no metastable reads
	assign fall = line_d_r & ~sync2_r;
	assign rise = ~line_d_r & sync2_r;
	assign dis_inc = vfc_pulse & awake & ~vfc_sign_chg;

	// Two-flop sync; only the second flop is used by logic
	always_ff @(posedge ref_clk) begin
		sync1_r <= single_wire_data_pin_i;
		sync2_r <= sync1_r;
		line_d_r <= sync2_r;
	end

	// Sleep and wake; any edge starts wake-up
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			awake <= 1'b1;
			wake_r <= '0;
		end else if (!awake) begin
			if (wake_r != '0) begin
				if (wake_r == CNT_W'(C_WAKE)) begin
					awake <= 1'b1;
					wake_r <= '0;
				end else begin
					wake_r <= wake_r + 1'b1;
				end
			end else if (fall || rise) begin
				wake_r <= CNT_W'(1);
			end
		end else if (sleep_req) begin
			awake <= 1'b0;
		end
	end

	// Slot engine: timing from falling edge; reset overrides all
	always_ff @(posedge ref_clk) begin
		rx_valid <= 1'b0;
		tx_taken <= 1'b0;
		if (sys_rst) begin
			state_r <= SWGL_IDLE;
			cnt_r <= '0;
			bit_r <= '0;
			sh_r <= '0;
			tx_r <= '0;
			tx_ok_r <= 1'b0;
			rx_byte <= '0;
			single_wire_data_pin_o <= 1'b0;
			single_wire_data_pin_oe <= 1'b0;
		end else begin
			single_wire_data_pin_o <= 1'b0;
			if (cnt_r != '1)
				cnt_r <= cnt_r + 1'b1;
			if (!tx_ok_r) begin
				// Latch next byte for read slots
				tx_r <= tx_byte;
				tx_ok_r <= 1'b1;
				tx_taken <= 1'b1;
			end
			case (state_r)
				SWGL_IDLE: begin
					// Slot starts on falling edge
					if (fall && awake) begin
						cnt_r <= '0;
						state_r <= SWGL_LOW;
						if (!tx_r[0]) begin
							// Read zero held from the strobe
							single_wire_data_pin_oe <= 1'b1;
							state_r <= SWGL_RDLOW;
						end
					end
				end
				SWGL_LOW: begin
					// Sample at 15 us: low means zero
					if (cnt_r == CNT_W'(C_SAMPLE)) begin
						sh_r <= {sync2_r, sh_r[7:1]};
						tx_r <= {1'b1, tx_r[7:1]};
						bit_r <= bit_r + 1'b1;
						if (bit_r == 3'd7) begin
							rx_byte <= {sync2_r, sh_r[7:1]};
							rx_valid <= 1'b1;
							tx_ok_r <= 1'b0;
						end
						state_r <= SWGL_WAITHI;
					end
					// A write one is released before 15 us; wait for the
					// sample point anyway, or every one bit would be lost
				end
				SWGL_RDLOW: begin
					// Hold zero past 15 us, release before 30
					if (cnt_r == CNT_W'(C_SAMPLE + C_US)) begin
						single_wire_data_pin_oe <= 1'b0;
						state_r <= SWGL_LOW;
						cnt_r <= CNT_W'(C_SAMPLE);
					end
				end
				SWGL_WAITHI: begin
					// Long low is a reset pulse
					if (sync2_r) begin
						state_r <= SWGL_IDLE;
					end else if (cnt_r >= CNT_W'(C_RSTL)) begin
						state_r <= SWGL_PDH;
					end
				end
				SWGL_PDH: begin
					// Wait for reset release, then presence delay
					if (!sync2_r) begin
						cnt_r <= '0;
					end else if (cnt_r == CNT_W'(C_PDH)) begin
						single_wire_data_pin_oe <= 1'b1;
						cnt_r <= '0;
						state_r <= SWGL_PDL;
					end
				end
				SWGL_PDL: begin
					if (cnt_r == CNT_W'(C_PDL)) begin
						single_wire_data_pin_oe <= 1'b0;
						bit_r <= '0;
						tx_ok_r <= 1'b0;
						state_r <= SWGL_IDLE; // Host waits 300 us
					end
				end
				default: state_r <= SWGL_IDLE;
			endcase
		end
	end

	// Erase timer: base plus per-byte time
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			er_cnt_r <= '0;
			erase_busy <= 1'b0;
		end else if (erase_start && !erase_busy) begin
			er_cnt_r <= 18'(C_ERASE_BASE) +
				18'(erase_bytes) * 18'(C_ERASE_BYTE);
			erase_busy <= 1'b1;
		end else if (erase_busy) begin
			er_cnt_r <= er_cnt_r - 1'b1;
			if (er_cnt_r == 18'd1)
				erase_busy <= 1'b0;
		end
	end

	// Hourly calibration strobe
	// One-cycle pulse; the count logic below applies the trim
	always_ff @(posedge ref_clk) begin
		cal_strobe <= 1'b0;
		if (sys_rst) begin
			cal_cnt_r <= '0;
		end else if (cal_cnt_r == 37'(CAL_PERIOD_CYC - 1)) begin
			cal_cnt_r <= '0;
			cal_strobe <= 1'b1;
		end else begin
			cal_cnt_r <= cal_cnt_r + 1'b1;
		end
	end

	// Count split by direction; calibration applies offset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			chg_count <= '0;
			dis_count <= '0;
		end else begin
			// Charge side is never trimmed, so it counts on strobe cycles
			if (vfc_pulse && awake && vfc_sign_chg)
				chg_count <= chg_count + 1'b1;
			if (cal_strobe) begin
				// Trim discharge side, keeping a count due now
				dis_count <= (dis_count + {15'h0, dis_inc} > cal_offset) ?
					dis_count + {15'h0, dis_inc} - cal_offset : '0;
			end else if (dis_inc) begin
				dis_count <= dis_count + 1'b1;
			end
		end
	end
endmodule : swgl_link

// [include/swgl_pkg.sv]
/*
 * Constants for the single-wire gauge link: slot timing, presence timing,
 * erase timing as cycle counts at 20 MHz, and calibration period in seconds.
 * Assumes a 20 MHz ref_clk; every count is derived from a time in ns or us.
 */
package swgl_pkg;
	localparam int CLK_PERIOD_NS = 50; // 20 MHz ref_clk
	// Times in microseconds as printed, calibration period in seconds
	localparam int T_SAMPLE_US = 15; // Write sample / read valid point
	localparam int T_REL_US = 30; // Read zero release limit
	localparam int T_RSTL_US = 480; // Least reset low
	localparam int T_PDH_US = 30; // Presence delay, inside 15-60
	localparam int T_PDL_US = 120; // Presence low, inside 60-240
	localparam int T_ERASE_BASE_US = 60; // Erase base time
	localparam int T_ERASE_BYTE_US = 30; // Erase time per byte
	localparam int T_WAKE_US = 300; // Wake-up limit
	localparam int T_CAL_S = 3600; // Calibration period
	// Cycle counts
	localparam int C_US = 1000 / CLK_PERIOD_NS; // Cycles per microsecond
	localparam int C_SAMPLE = T_SAMPLE_US * C_US;
	localparam int C_REL = T_REL_US * C_US;
	// Reset detect a little under the least, so a 480 us pulse counts
	localparam int C_RSTL = (T_RSTL_US - 20) * C_US;
	localparam int C_PDH = T_PDH_US * C_US;
	localparam int C_PDL = T_PDL_US * C_US;
	localparam int C_ERASE_BASE = T_ERASE_BASE_US * C_US;
	localparam int C_ERASE_BYTE = T_ERASE_BYTE_US * C_US;
	localparam int C_WAKE = T_WAKE_US * C_US / 4; // Well inside limit
	localparam int CNT_W = 16; // Width of timing counter
	localparam int BYTE_W = 8; // Link transfer group size
	localparam logic [7:0] ERASE_CMD_RST = 8'h00; // Erase length reset
endpackage : swgl_pkg

// [verification/swgl_link_checker.sv]
/* Timing checker for the gauge link device end.
 * Assumes an external pull-up; oe high pulls the line low. */
`timescale 1ns/100ps
module swgl_link_checker #(
	parameter int CAL_PERIOD_CYC = 1000 // Calibration period
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic single_wire_data_pin_i,
	input wire logic single_wire_data_pin_o,
	input wire logic single_wire_data_pin_oe,
	input wire logic rx_valid,
	input wire logic awake,
	input wire logic erase_start,
	input wire logic [7:0] erase_bytes,
	input wire logic erase_busy,
	input wire logic cal_strobe,
	input wire logic vfc_pulse,
	input wire logic vfc_sign_chg,
	input wire logic [15:0] chg_count,
	input wire logic [15:0] dis_count
);
	logic [15:0] low_r; // Line low run, saturates
	logic [15:0] oe_r; // Device drive run
	logic [17:0] ers_r; // Erase busy run
	logic [17:0] ers_exp_r; // Erase length owed
	logic [31:0] cal_r; // Cycles since strobe
	logic [15:0] pd_r; // Cycles since reset pulse released
	logic [15:0] wk_r; // Cycles since wake-up edge
	logic pin_d_r; // Line one cycle ago
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Run lengths; the low run saturates so a stuck line cannot wrap
	always_ff @(posedge ref_clk) begin
		low_r <= single_wire_data_pin_i ? 16'h0 : low_r + {15'h0, ~&low_r};
		oe_r <= single_wire_data_pin_oe ? oe_r + 16'h1 : 16'h0;
		ers_r <= erase_busy ? ers_r + 18'h1 : 18'h0;
		cal_r <= (sys_rst || cal_strobe) ? 32'h0 : cal_r + 32'h1;
		pin_d_r <= single_wire_data_pin_i;
	end
	// Presence and wake delays counted here, not by long delay ranges
	always_ff @(posedge ref_clk) begin
		if (sys_rst || single_wire_data_pin_oe)
			pd_r <= 16'h0;
		else if (pd_r != 16'h0)
			pd_r <= pd_r + 16'h1;
		else if (single_wire_data_pin_i && !pin_d_r && low_r >= 16'd9600)
			pd_r <= 16'h1;
		if (sys_rst || awake)
			wk_r <= 16'h0;
		else if (wk_r != 16'h0)
			wk_r <= wk_r + 16'h1;
		else if (pin_d_r && !single_wire_data_pin_i)
			wk_r <= 16'h1;
	end
	// Erase length taken at the accepted start
	always_ff @(posedge ref_clk) begin
		if (erase_start && !erase_busy) begin
			ers_exp_r <= 18'd1200 + 18'(erase_bytes) * 18'd600;
		end
	end
	AST_PIN_LOW: assert property (!single_wire_data_pin_o)
		else $error("data pin driven high");
	AST_PRES: assert property ($rose(single_wire_data_pin_oe) &&
		pd_r != 16'h0 |-> pd_r >= 16'd300)
		else $error("presence too early");
	AST_PRES_LATE: assert property (pd_r <= 16'd1200)
		else $error("presence late or missing");
	AST_OE_MAX: assert property (oe_r <= 16'd4800)
		else $error("line held too long");
	AST_ERASE: assert property ($fell(erase_busy)
		|-> ers_r + 18'd2 >= ers_exp_r && ers_r <= ers_exp_r + 18'd2)
		else $error("erase length wrong");
	AST_CAL: assert property (cal_strobe
		|-> cal_r + 2 >= CAL_PERIOD_CYC && cal_r <= CAL_PERIOD_CYC)
		else $error("calibration period wrong");
	AST_CHG: assert property (awake && vfc_pulse && vfc_sign_chg
		|=> chg_count == $past(chg_count) + 16'h1)
		else $error("charge count missed");
	AST_DIS: assert property (awake && vfc_pulse && !vfc_sign_chg && !cal_strobe
		|=> dis_count == $past(dis_count) + 16'h1)
		else $error("discharge count missed");
	AST_WAKE: assert property (wk_r <= 16'd6000)
		else $error("wake too slow");
	AST_MUTE: assert property (!awake |-> !single_wire_data_pin_oe)
		else $error("drive while asleep");
	AST_RXP: assert property (rx_valid |=> !rx_valid)
		else $error("byte flag too long");
endmodule : swgl_link_checker
bind swgl_link swgl_link_checker #(.CAL_PERIOD_CYC(CAL_PERIOD_CYC)) chk (.*);

// [verification/swgl_host.sv]
/* Behavioural bus master for the gauge link.
 * Assumes a 20 MHz clock; acts only on falling edges. */
`timescale 1ns/100ps
module swgl_host (
	input wire logic ref_clk,
	input wire logic single_wire_data_pin_i, // Wired level
	output logic drive_low // High pulls line low
);
	initial drive_low = 1'b0;
	// Whole microseconds on falling edges
	task automatic wait_us(input int n);
		repeat (n * 20) @(negedge ref_clk);
	endtask : wait_us
	// Reset, then measure delay to presence
	task automatic reset_link(output logic [15:0] dly);
		dly = 16'hFFFF;
		drive_low = 1'b1;
		wait_us(500);
		drive_low = 1'b0;
		for (int i = 0; i < 6000; i++) begin
			@(negedge ref_clk);
			if (!single_wire_data_pin_i && dly == 16'hFFFF) dly = 16'(i);
		end
	endtask : reset_link
	// One 90 us slot: write b, read r
	task automatic slot(input logic b, output logic r);
		drive_low = 1'b1;
		wait_us(b ? 5 : 80);
		drive_low = 1'b0;
		if (b) wait_us(8);
		r = single_wire_data_pin_i;
		wait_us(b ? 77 : 10);
	endtask : slot
	// Byte, least significant bit first
	task automatic xfer(input logic [7:0] w, output logic [7:0] rd);
		for (int i = 0; i < 8; i++) slot(w[i], rd[i]);
	endtask : xfer
endmodule : swgl_host

// [verification/swgl_link_tb.sv]
/* Self-checking bench for the gauge link device end.
 * Assumes the host model and checker beside it; pull-up modelled. */
`timescale 1ns/100ps
module swgl_link_tb;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic drive_low, single_wire_data_pin_o, single_wire_data_pin_oe;
	logic rx_valid, tx_taken, awake, erase_busy, cal_strobe;
	logic [7:0] rx_byte, rd, got;
	logic [7:0] tx_byte = 8'hFF; // Ones keep write slots clean
	logic sleep_req = 1'b0, erase_start = 1'b0;
	logic vfc_pulse = 1'b0, vfc_sign_chg = 1'b0;
	logic [7:0] erase_bytes = 8'h03;
	logic [15:0] cal_offset = 16'h0000; // Zero: counts stay exact
	logic [15:0] chg_count, dis_count, b0, d0;
	int bad_count = 0, checked = 0, nrx = 0, cyc = 0, n;
	int ntx = 0; // Bytes taken for read slots
	// Wired line: pull-up unless someone pulls low
	wire single_wire_data_pin_i = !(drive_low | single_wire_data_pin_oe);
	swgl_link #(.CAL_PERIOD_CYC(1000)) uut (.*);
	swgl_host host (.*);
	always #25 ref_clk = ~ref_clk;
	// Catch received bytes; flag lasts one cycle
	always @(posedge ref_clk) if (rx_valid === 1'b1) begin
		got = rx_byte;
		nrx++;
	end
	// Count bytes latched for sending
	always @(posedge ref_clk) if (tx_taken === 1'b1) ntx++;
	// Hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 90000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic t_presence();
		host.reset_link(b0);
		check(16'(b0 >= 300 && b0 <= 1200), 16'h1);
	endtask : t_presence
	task automatic t_write();
		n = nrx;
		host.xfer(8'hA5, rd);
		check(got, 8'hA5);
		check(16'(nrx - n), 16'h1);
	endtask : t_write
	task automatic t_read();
		tx_byte = 8'h3C;
		n = ntx;
		host.xfer(8'hFF, rd);
		host.xfer(8'hFF, rd);
		check(rd, 8'h3C);
		check(16'(ntx - n), 16'h2);
	endtask : t_read
	task automatic t_count();
		b0 = chg_count;
		d0 = dis_count;
		vfc_sign_chg = 1'b1;
		vfc_pulse = 1'b1;
		repeat (3) @(negedge ref_clk);
		vfc_sign_chg = 1'b0;
		repeat (2) @(negedge ref_clk);
		vfc_pulse = 1'b0;
		repeat (3) @(negedge ref_clk);
		check(chg_count, b0 + 16'h3);
		check(dis_count, d0 + 16'h2);
	endtask : t_count
	task automatic t_erase();
		erase_start = 1'b1;
		@(negedge ref_clk);
		erase_start = 1'b0;
		for (n = 0; erase_busy === 1'b1 && n < 5000; n++) @(negedge ref_clk);
		check(16'(n >= 2995 && n <= 3002), 16'h1);
	endtask : t_erase
	task automatic t_sleep();
		sleep_req = 1'b1;
		repeat (20) @(negedge ref_clk);
		check(awake, 1'b0);
		sleep_req = 1'b0;
		host.slot(1'b1, rd[0]);
		check(awake, 1'b1);
	endtask : t_sleep
	// Main sequence
	initial begin
		repeat (12) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		t_presence();
		t_write();
		t_read();
		t_count();
		t_erase();
		t_sleep();
		report_and_stop();
	end
endmodule : swgl_link_tb
